//--- core/ltf_buf.sv
// Input buffer of flits with last and poison marks, first in first out.
// Assumes the writer never overruns it; tokens guarantee the space.
`timescale 1ns/1ps
module ltf_buf #(
  parameter int W = 130,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [W-1:0] wr_data,
  input wire logic rd_en,
  output logic [W-1:0] rd_data,
  output logic empty,
  output logic [$clog2(DEPTH):0] count
);
  import ltf_pkg::*;
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic wr_ok, rd_ok;

  always_comb begin
    wr_ok = wr_en && (cnt_q != (AW+1)'(DEPTH));
    rd_ok = rd_en && (cnt_q != '0);
    wp_d = wp_q;
    rp_d = rp_q;
    if (wr_ok) wp_d = (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
    if (rd_ok) rp_d = (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
    cnt_d = cnt_q + (AW+1)'(wr_ok) - (AW+1)'(rd_ok);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage needs no reset; nothing reads an entry before it is written
  always_ff @(posedge clk) begin
    if (wr_ok) mem[wp_q] <= wr_data;
  end

  assign rd_data = mem[rp_q];
  assign empty = (cnt_q == '0);
  assign count = cnt_q;
endmodule // ltf_buf

//--- core/ltf_crc.sv
// Combinational CRC step over one flit, most significant bit first.
// Assumes the caller zeroes the CRC field of a tail flit before feeding it.
`timescale 1ns/1ps
module ltf_crc (
  input wire logic [ltf_pkg::CRC_W-1:0] crc_in,
  input wire logic [ltf_pkg::FLIT_W-1:0] data,
  output logic [ltf_pkg::CRC_W-1:0] crc_out
);
  import ltf_pkg::*;
  always_comb begin
    logic [CRC_W-1:0] c;
    logic fb;
    c = crc_in;
    fb = 1'b0;
    for (int i = FLIT_W - 1; i >= 0; i--) begin
      fb = c[CRC_W-1] ^ data[i];
      c = {c[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : 32'h00000000);
    end
    crc_out = c;
  end
endmodule // ltf_crc

//--- core/ltf_top.sv
// Device end of one link: token flow control, return tokens and CRC poisoning.
// Assumes the far end honours tokens, and the source and sink hold valid flits.
`timescale 1ns/1ps
module ltf_top #(
  parameter int BUF_DEPTH = 16,
  parameter int MAX_PKT_FLITS = 9,
  parameter int TOK_MAX_RST = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rx_valid,
  input wire logic [ltf_pkg::FLIT_W-1:0] rx_flit,
  output logic fwd_valid,
  output logic [ltf_pkg::FLIT_W-1:0] fwd_flit,
  output logic fwd_last,
  output logic fwd_poison,
  input wire logic fwd_ready,
  input wire logic src_valid,
  input wire logic [ltf_pkg::FLIT_W-1:0] src_flit,
  output logic src_ready,
  output logic tx_valid,
  output logic [ltf_pkg::FLIT_W-1:0] tx_flit,
  output logic tx_last
);
  import ltf_pkg::*;
  localparam int BW = FLIT_W + 2;
  localparam int B_LAST = FLIT_W;
  localparam int B_PSN = FLIT_W + 1;
  localparam int CW = $clog2(BUF_DEPTH) + 1;

  // Bus slave state
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic ctrl_en_q, ctrl_en_d;
  logic init_q, init_d;
  logic [CNT_W-1:0] tok_max_q, tok_max_d;
  logic [STAT_W-1:0] stat_q, stat_d;
  logic [STAT_W-1:0] stat_set;
  logic [31:0] wmask, merged;
  logic wr_go;
  logic [STAT_W-1:0] clr;

  // Receive side
  logic [LEN_W-1:0] rx_left_q, rx_left_d;
  logic [CRC_W-1:0] rx_crc_q, rx_crc_d;
  logic rx_flow_q, rx_flow_d;
  logic rx_hdr, rx_flow, rx_last, rx_tail;
  logic rx_ok, rx_inv, rx_bad, rtc_take;
  logic [CRC_W-1:0] rx_tcrc, rx_crc_in, rx_crc_out;
  logic [FLIT_W-1:0] rx_fix;
  logic buf_wr, buf_empty, rd_en;
  logic [BW-1:0] buf_wd, buf_rd;
  logic [CW-1:0] buf_cnt;

  // Forward side
  logic fwd_valid_q, fwd_valid_d;
  logic [FLIT_W-1:0] fwd_flit_q, fwd_flit_d;
  logic fwd_last_q, fwd_last_d;
  logic fwd_psn_q, fwd_psn_d;
  logic [LEN_W-1:0] rd_cnt_q, rd_cnt_d;
  logic [CNT_W-1:0] free_n;

  // Transmit side
  logic [LEN_W-1:0] tx_left_q, tx_left_d;
  logic [CRC_W-1:0] tx_chk_q, tx_chk_d, tx_gen_q, tx_gen_d;
  logic [CRC_W-1:0] chk_in, chk_out, gen_in, gen_out;
  logic src_ready_q, src_ready_d;
  logic tx_valid_q, tx_valid_d;
  logic [FLIT_W-1:0] tx_flit_q, tx_flit_d;
  logic tx_last_q, tx_last_d;
  logic [CNT_W-1:0] tok_q, tok_d, lim_q, lim_d, pend_q, pend_d;
  logic tx_start, take, s_flow, token_return_packet, o_go, o_last, orig_bad, ovf_ev;
  logic [LEN_W-1:0] s_len;
  logic [FLIT_W-1:0] o_raw, o_mod, token_return_packet_flit;
  logic [RTC_W-1:0] enc;
  logic [CNT_W-1:0] used, dec, add;
  logic [CNT_W:0] sum;

  // Registers: one wait state, then the answer
  always_comb begin
    wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
             {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wr_go = avs_write && !wait_q;
    wait_d = !(wait_q && (avs_read || avs_write));
    rdata_d = rdata_q;
    ctrl_en_d = ctrl_en_q;
    init_d = 1'b0;
    tok_max_d = tok_max_q;
    clr = '0;
    merged = ({HALF_W'(0), tok_max_q} & ~wmask) | (avs_writedata & wmask);
    if (avs_read && wait_q) begin
      rdata_d = 32'h00000000;
      case (avs_address)
        REG_CTRL: rdata_d[CTRL_EN] = ctrl_en_q;
        REG_TMAX: rdata_d = {HALF_W'(0), tok_max_q};
        REG_TOK: rdata_d = {lim_q, tok_q};
        REG_STAT: rdata_d = {(32 - STAT_W)'(0), stat_q};
        REG_PEND: rdata_d = {HALF_W'(buf_cnt), pend_q};
        default: rdata_d = 32'h00000000;
      endcase
    end
    if (wr_go) begin
      case (avs_address)
        REG_CTRL: begin
          if (avs_byteenable[0]) begin
            ctrl_en_d = avs_writedata[CTRL_EN];
            init_d = avs_writedata[CTRL_INIT];
          end
        end
        REG_TMAX: tok_max_d = merged[CNT_W-1:0];
        REG_STAT: clr = avs_writedata[STAT_W-1:0] & {STAT_W{avs_byteenable[0]}};
        default: clr = '0;
      endcase
    end
    // Set wins over a clear in the same cycle
    stat_d = (stat_q & ~clr) | stat_set;
  end

  // Receive parse, CRC check and poisoning
  ltf_crc u_rx_crc (
    .crc_in(rx_crc_in),
    .data(crc_mask(rx_flit, rx_last)),
    .crc_out(rx_crc_out)
  );

  always_comb begin
    rx_hdr = (rx_left_q == 5'h00);
    rx_flow = rx_hdr ? is_flow(rx_flit) : rx_flow_q;
    rx_last = rx_hdr ? (flit_len(rx_flit) == 5'h01) : (rx_left_q == 5'h01); // [R1][R25]
    rx_crc_in = rx_hdr ? CRC_INIT : rx_crc_q;
    rx_tcrc = rx_flit[CRC_LSB +: CRC_W]; // [R27]
    rx_tail = rx_valid && rx_last;
    rx_ok = (rx_tcrc == rx_crc_out);
    rx_inv = (rx_tcrc == ~rx_crc_out);
    rx_bad = rx_tail && !rx_ok && !rx_inv;
    // Flow fields still count on a marked packet, not on a corrupt one
    rtc_take = rx_tail && !rx_bad; // [R9][R23]
    rx_fix = rx_flit;
    if (rx_bad) rx_fix[CRC_LSB +: CRC_W] = ~rx_crc_out; // [R20]
    buf_wr = rx_valid && !rx_flow; // [R3]
    buf_wd = {rx_tail && !rx_ok, rx_last, rx_fix};
    rx_left_d = rx_left_q;
    rx_crc_d = rx_crc_q;
    rx_flow_d = rx_flow_q;
    if (rx_valid) begin
      rx_left_d = rx_hdr ? flit_len(rx_flit) - 5'h01 : rx_left_q - 5'h01;
      rx_crc_d = rx_crc_out;
      rx_flow_d = rx_flow;
    end
    stat_set = '0;
    stat_set[STAT_CRC] = rx_bad;
    stat_set[STAT_PSN] = rx_tail && rx_inv;
    stat_set[STAT_OVF] = ovf_ev;
  end

  // No bypass of an empty buffer; every non-flow flit is stored so tokens return on read-out
  ltf_buf #(
    .W(BW),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(buf_wr),
    .wr_data(buf_wd),
    .rd_en(rd_en),
    .rd_data(buf_rd),
    .empty(buf_empty),
    .count(buf_cnt)
  ); // [R4][R11]

  // Forward towards the destination; poisoned packets are flagged for dropping
  always_comb begin
    rd_en = !buf_empty && (!fwd_valid_q || fwd_ready);
    fwd_valid_d = rd_en ? 1'b1 : (fwd_ready ? 1'b0 : fwd_valid_q);
    fwd_flit_d = rd_en ? buf_rd[FLIT_W-1:0] : fwd_flit_q;
    fwd_last_d = rd_en ? buf_rd[B_LAST] : fwd_last_q;
    fwd_psn_d = rd_en ? buf_rd[B_PSN] : fwd_psn_q; // [R21]
    rd_cnt_d = rd_cnt_q;
    free_n = '0;
    if (rd_en) begin
      rd_cnt_d = buf_rd[B_LAST] ? 5'h00 : rd_cnt_q + 5'h01;
      if (buf_rd[B_LAST]) free_n = CNT_W'(rd_cnt_q) + 16'h0001; // [R7][R2]
    end
  end

  // Transmit: token check, return-token insertion and CRC regeneration
  ltf_crc u_chk_crc (
    .crc_in(chk_in),
    .data(crc_mask(o_raw, o_last)),
    .crc_out(chk_out)
  );

  ltf_crc u_gen_crc (
    .crc_in(gen_in),
    .data(crc_mask(o_mod, o_last)),
    .crc_out(gen_out)
  );

  always_comb begin
    tx_start = (tx_left_q == 5'h00);
    take = src_valid && src_ready_q;
    s_flow = is_flow(src_flit);
    s_len = flit_len(src_flit); // [R25]
    token_return_packet = !take && tx_start && (pend_q != '0) && ctrl_en_q; // [R10]
    token_return_packet_flit = '0;
    token_return_packet_flit[CMD_W-1:0] = CMD_TOKEN_RETURN_PACKET;
    token_return_packet_flit[LEN_LSB +: LEN_W] = 5'h01;
    // Header passed untouched: the tag is copied, never looked at
    o_raw = take ? src_flit : token_return_packet_flit; // [R13][R15][R16][R17][R26]
    o_last = take ? (tx_start ? (s_len == 5'h01) : (tx_left_q == 5'h01)) : 1'b1;
    o_go = take || token_return_packet;
    enc = rtc_enc(pend_q);
    used = (o_go && o_last) ? rtc_dec(enc) : '0;
    o_mod = o_raw;
    if (o_last) o_mod[RTC_LSB +: RTC_W] = enc; // [R8][R24]
    chk_in = tx_start ? CRC_INIT : tx_chk_q;
    gen_in = tx_start ? CRC_INIT : tx_gen_q;
    // Old CRC checked alongside the new one, so a fault in between is not hidden
    orig_bad = take && (o_raw[CRC_LSB +: CRC_W] != chk_out); // [R19]
    tx_flit_d = tx_flit_q;
    if (o_go) begin
      tx_flit_d = o_mod;
      if (o_last) tx_flit_d[CRC_LSB +: CRC_W] = orig_bad ? ~gen_out : gen_out; // [R22]
    end
    tx_valid_d = o_go;
    tx_last_d = o_go ? o_last : tx_last_q;
    tx_chk_d = o_go ? chk_out : tx_chk_q;
    tx_gen_d = o_go ? gen_out : tx_gen_q;
    tx_left_d = tx_left_q;
    if (o_go) tx_left_d = tx_start ? (take ? s_len - 5'h01 : 5'h00) : tx_left_q - 5'h01;
    dec = (take && tx_start && !s_flow) ? CNT_W'(s_len) : '0; // [R6][R3]
    add = rtc_take ? rtc_dec(rx_flit[RTC_LSB +: RTC_W]) : '0; // [R9]
    sum = {1'b0, tok_q} + {1'b0, add} - {1'b0, dec};
    ovf_ev = 1'b0;
    lim_d = lim_q;
    if (init_q) begin
      tok_d = tok_max_q; // [R5]
      lim_d = tok_max_q;
    end else if (sum > {1'b0, lim_q}) begin
      tok_d = lim_q; // [R28]
      ovf_ev = 1'b1;
    end else begin
      tok_d = sum[CNT_W-1:0];
    end
    // Ready is registered, so a waiting header is judged one cycle ahead
    src_ready_d = (tx_left_d != 5'h00) ||
                  (ctrl_en_q && src_valid && !take &&
                   (s_flow || tok_d >= CNT_W'(s_len))); // [R12]
    pend_d = pend_q - used + free_n; // [R7][R8]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
      ctrl_en_q <= CTRL_EN_RST;
      init_q <= 1'b0;
      tok_max_q <= CNT_W'(TOK_MAX_RST);
      stat_q <= '0;
      rx_left_q <= '0;
      rx_crc_q <= CRC_INIT;
      rx_flow_q <= 1'b0;
      fwd_valid_q <= 1'b0;
      fwd_flit_q <= '0;
      fwd_last_q <= 1'b0;
      fwd_psn_q <= 1'b0;
      rd_cnt_q <= '0;
      tx_left_q <= '0;
      tx_chk_q <= CRC_INIT;
      tx_gen_q <= CRC_INIT;
      src_ready_q <= 1'b0;
      tx_valid_q <= 1'b0;
      tx_flit_q <= '0;
      tx_last_q <= 1'b0;
      tok_q <= CNT_W'(TOK_MAX_RST); // [R5]
      lim_q <= CNT_W'(TOK_MAX_RST);
      pend_q <= '0;
    end else begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      ctrl_en_q <= ctrl_en_d;
      init_q <= init_d;
      tok_max_q <= tok_max_d;
      stat_q <= stat_d;
      rx_left_q <= rx_left_d;
      rx_crc_q <= rx_crc_d;
      rx_flow_q <= rx_flow_d;
      fwd_valid_q <= fwd_valid_d;
      fwd_flit_q <= fwd_flit_d;
      fwd_last_q <= fwd_last_d;
      fwd_psn_q <= fwd_psn_d;
      rd_cnt_q <= rd_cnt_d;
      tx_left_q <= tx_left_d;
      tx_chk_q <= tx_chk_d;
      tx_gen_q <= tx_gen_d;
      src_ready_q <= src_ready_d;
      tx_valid_q <= tx_valid_d;
      tx_flit_q <= tx_flit_d;
      tx_last_q <= tx_last_d;
      tok_q <= tok_d;
      lim_q <= lim_d;
      pend_q <= pend_d;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign fwd_valid = fwd_valid_q;
  assign fwd_flit = fwd_flit_q;
  assign fwd_last = fwd_last_q;
  assign fwd_poison = fwd_psn_q;
  assign src_ready = src_ready_q;
  assign tx_valid = tx_valid_q;
  assign tx_flit = tx_flit_q;
  assign tx_last = tx_last_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_buf_depth_ok: assert property (BUF_DEPTH >= MAX_PKT_FLITS) // [R4]
    else $error("input buffer shorter than longest packet");
  a_hold_stream: assert property (take && tx_start && !s_flow |-> tok_q >= CNT_W'(s_len)) // [R12]
    else $error("packet started without enough tokens");
  a_tok_decrement: assert property (dec != '0 && !rtc_take && !init_q // [R6]
    |=> tok_q == $past(tok_q) - $past(dec))
    else $error("token counter not reduced by packet length");
  a_rtc_add: assert property (rtc_take && dec == '0 && !init_q && !ovf_ev // [R9]
    |=> tok_q == $past(tok_q) + $past(add))
    else $error("returned tokens not added");
  a_init_load: assert property (init_q |=> tok_q == $past(tok_max_q) && lim_q == tok_q) // [R5]
    else $error("token counter not loaded at init");
  a_tok_limit: assert property (tok_q <= lim_q) // [R28]
    else $error("token counter above loaded maximum");
  a_flow_nobuf: assert property (rx_valid && rx_flow && !rd_en // [R3]
    |=> buf_cnt == $past(buf_cnt))
    else $error("flow packet written to input buffer");
  a_token_return_packet_gen: assert property (token_return_packet // [R10]
    |=> tx_valid_q && tx_last_q && tx_flit_q[CMD_W-1:0] == CMD_TOKEN_RETURN_PACKET)
    else $error("token return packet not sent");
  a_poison_crc: assert property (rx_bad |-> buf_wd[CRC_LSB +: CRC_W] == ~rx_crc_out) // [R20]
    else $error("bad packet not poisoned");
  a_rtc_insert: assert property (o_go && o_last // [R8]
    |=> tx_flit_q[RTC_LSB +: RTC_W] == $past(enc) && pend_q == $past(pend_q) - $past(used) + $past(free_n))
    else $error("return tokens not carried out");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered after one wait");

  c_token_return_packet_sent: cover property (token_return_packet ##1 tx_valid_q);
  c_poisoned: cover property (rx_bad);
  c_held: cover property (src_valid && !src_ready_q && tx_start ##1 src_valid && src_ready_q);
  c_marked_in: cover property (rx_tail && rx_inv);
endmodule // ltf_top

//--- include/ltf_pkg.sv
// Constants, field layout and helpers for the link token, tag and poison framer.
// Assumes 128-bit flits, header in the low half and tail in the high half of a flit.
// How it works
// R1: Packets are whole 16-byte flits; length counts header, payload and tail.
// R2: One token buys space for exactly one flit in the far input buffer.
// R3: Flow packets skip the input buffer and neither use nor need tokens.
// R4: Input buffer holds at least one packet of the longest length.
// R5: Initialisation loads the token counter with the empty far-buffer maximum.
// R6: Sending a transaction packet subtracts its length from the token counter.
// R7: Flits read out of the input buffer are handed to the local transmitter.
// R8: Freed flits ride in the return-token field of the next outgoing packet.
// R9: Return tokens of every incoming packet are added to the token counter; the code skips packets with a bad CRC.
// R10: With no outgoing traffic a token-return flow packet carries pending tokens.
// R11: A packet may bypass an empty input buffer, returning tokens at once; the code never bypasses it and stores every non-flow flit.
// R12: Hold the outgoing stream while tokens are fewer than the packet length.
// R13: Responses carry the tag of their read or non-posted write request.
// R14: Posted writes get no response; their tag may hold anything.
// R15: Responses leave on the link that carried the request.
// R16: Tags are eleven bits; all 2048 values are legal per link.
// R17: The tag is only copied, never used for control.
// R18: The requester reuses a tag only after its response returned.
// R19: CRC covers the whole packet; regeneration overlaps checking of the old.
// R20: A forwarded request with a bad CRC gets its recomputed CRC inverted.
// R21: Packets with inverted CRC are discarded at the destination.
// R22: Inserting flow fields into a marked packet keeps the CRC inverted.
// R23: Marked packets still give flow fields; command, address, tag are invalid.
// R24: Return-token field sits at tail bits 31 to 29, encoded.
// R25: Length field sits at header bits 11 to 7, in 128-bit flits.
// R26: Tag field sits at header bits 22 to 12.
// R27: The 32-bit CRC sits at tail bits 63 to 32.
// R28: Token counter never exceeds its loaded value; excess is an error.
package ltf_pkg;
  localparam int FLIT_W = 128;
  localparam int CMD_W = 7;
  localparam int LEN_LSB = 7;
  localparam int LEN_W = 5;
  localparam int TAG_LSB = 12;
  localparam int TAG_W = 11;
  localparam int TAIL_LSB = 64;
  localparam int RTC_LSB = TAIL_LSB + 29;
  localparam int RTC_W = 3;
  localparam int CRC_LSB = TAIL_LSB + 32;
  localparam int CRC_W = 32;
  localparam int CNT_W = 16;
  localparam logic [CRC_W-1:0] CRC_INIT = 32'h00000000;
  localparam logic [CRC_W-1:0] CRC_POLY = 32'h04C11DB7;
  localparam logic [CMD_W-1:0] CMD_TOKEN_RETURN_PACKET = 7'h02;
  localparam logic [3:0] FLOW_HI = 4'h0;
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_TMAX = 3'h1;
  localparam logic [2:0] REG_TOK = 3'h2;
  localparam logic [2:0] REG_STAT = 3'h3;
  localparam logic [2:0] REG_PEND = 3'h4;
  localparam int CTRL_EN = 0;
  localparam int CTRL_INIT = 1;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int STAT_OVF = 0;
  localparam int STAT_CRC = 1;
  localparam int STAT_PSN = 2;
  localparam int STAT_W = 3;
  localparam int HALF_W = 16;

  function automatic logic [RTC_W-1:0] rtc_enc(input logic [CNT_W-1:0] n);
    return (n > 16'h0007) ? 3'h7 : n[RTC_W-1:0];
  endfunction

  function automatic logic [CNT_W-1:0] rtc_dec(input logic [RTC_W-1:0] e);
    return {13'h0000, e};
  endfunction

  function automatic logic is_flow(input logic [FLIT_W-1:0] f);
    return f[CMD_W-1:3] == FLOW_HI;
  endfunction

  function automatic logic [LEN_W-1:0] flit_len(input logic [FLIT_W-1:0] f);
    logic [LEN_W-1:0] l;
    l = f[LEN_LSB +: LEN_W];
    return (l == 5'h00) ? 5'h01 : l;
  endfunction

  function automatic logic [FLIT_W-1:0] crc_mask(input logic [FLIT_W-1:0] f,
                                                 input logic last);
    logic [FLIT_W-1:0] m;
    m = f;
    if (last) m[CRC_LSB +: CRC_W] = 32'h00000000;
    return m;
  endfunction
endpackage

//--- test/ltf_far.sv
// Far end of the link: takes device flits, keeps the last header, sums tokens.
// Assumes one flit per cycle on tx_valid, tx_last marking each tail.
`timescale 1ns/1ps
module ltf_far (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tx_valid,
  input wire logic [ltf_pkg::FLIT_W-1:0] tx_flit,
  input wire logic tx_last,
  output logic [15:0] rtc_sum_q,
  output logic [ltf_pkg::FLIT_W-1:0] hdr_q
);
  import ltf_pkg::*;
  logic first_q;
  // Tokens credited from every tail, marked ones too
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rtc_sum_q <= 16'h0000;
      hdr_q <= '0;
      first_q <= 1'b1;
    end else if (tx_valid) begin
      if (first_q) hdr_q <= tx_flit;
      first_q <= tx_last;
      if (tx_last) rtc_sum_q <= rtc_sum_q + 16'(tx_flit[RTC_LSB +: RTC_W]);
    end
  end
endmodule // ltf_far

//--- test/tb_top.sv
// Self-checking bench for the link token, tag and poison framer.
// Assumes ltf_pkg, ltf_top and ltf_far compiled before it.
`timescale 1ns/1ps
module tb_top;
  import ltf_pkg::*;
  logic clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, rx_valid = 0, fwd_ready = 1;
  logic [2:0] avs_address = 3'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic avs_waitrequest, fwd_valid, fwd_last, fwd_poison, src_valid = 0, src_ready;
  logic tx_valid, tx_last;
  logic [FLIT_W-1:0] rx_flit = '0, fwd_flit, src_flit = '0, tx_flit, hdr, f;
  logic [15:0] rtc_sum, s0;
  logic [129:0] g, fq[$];
  int miscompares = 0, checks_done = 0, wt;
  always #5 clk = ~clk;
  ltf_top DUT (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid),
    .rx_flit(rx_flit), .fwd_valid(fwd_valid), .fwd_flit(fwd_flit), .fwd_last(fwd_last),
    .fwd_poison(fwd_poison), .fwd_ready(fwd_ready), .src_valid(src_valid),
    .src_flit(src_flit), .src_ready(src_ready), .tx_valid(tx_valid), .tx_flit(tx_flit),
    .tx_last(tx_last));
  ltf_far far (.clk(clk), .rst_n(rst_n), .tx_valid(tx_valid), .tx_flit(tx_flit),
    .tx_last(tx_last), .rtc_sum_q(rtc_sum), .hdr_q(hdr));
  always @(posedge clk) if (fwd_valid === 1'b1 && fwd_ready === 1'b1)
    fq.push_back({fwd_poison, fwd_last, fwd_flit});
  function automatic logic [31:0] crc(input logic [FLIT_W-1:0] d);
    logic [31:0] c;
    c = CRC_INIT;
    for (int i = FLIT_W - 1; i >= 0; i--) c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? CRC_POLY : 32'h0);
    return c;
  endfunction
  // Mode 0 good code, 1 plain error, 2 inverted (marked)
  function automatic logic [FLIT_W-1:0] mk(input logic [6:0] c, input logic [4:0] n,
      input logic [10:0] t, input logic [2:0] r, input logic [1:0] m);
    logic [FLIT_W-1:0] p;
    p = '0;
    p[CMD_W-1:0] = c;
    p[LEN_LSB +: LEN_W] = n;
    p[TAG_LSB +: TAG_W] = t;
    p[RTC_LSB +: RTC_W] = r;
    p[CRC_LSB +: CRC_W] = (m == 2'h2) ? ~crc(p) : crc(p) ^ {31'h0, m[0]};
    return p;
  endfunction
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic tmo;
    miscompares++;
    $display("ERROR %0t wait ran out", $time);
    wrap_up();
  endtask
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_f(input logic [129:0] got, input logic [129:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t flit %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 20) tmo();
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk_w(q, e);
  endtask
  task automatic put(input logic [FLIT_W-1:0] p);
    @(posedge clk);
    src_valid <= 1'b1;
    src_flit <= p;
    for (wt = 0; wt < 60; wt++) begin
      @(posedge clk);
      if (src_ready === 1'b1) break;
    end
    if (wt == 60) tmo();
    src_valid <= 1'b0;
    src_flit <= ~p;
  endtask
  // Idle link data flips so a stale flit never looks valid
  task automatic rx(input logic [FLIT_W-1:0] p);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_flit <= p;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_flit <= ~p;
  endtask
  task automatic getf;
    int n;
    for (n = 0; n < 40 && fq.size() == 0; n++) @(posedge clk);
    if (fq.size() == 0) tmo();
    g = fq.pop_front();
  endtask
  task automatic s_regs;
    rd(REG_CTRL, 32'h1);
    rd(REG_TMAX, 32'h10);
    rd(REG_TOK, 32'h00100010);
    rd(REG_STAT, 32'h0);
    bus(1'b1, REG_TOK, 32'h0);
    rd(REG_TOK, 32'h00100010);
    rd(3'h7, 32'h0);
  endtask
  // Header and tag copied untouched, whole flit count taken from tokens
  task automatic s_tx;
    f = mk(7'h38, 5'h02, 11'h5A5, 3'h0, 2'h0);
    put(f);
    put('0);
    repeat (3) @(posedge clk);
    chk_f({2'b00, hdr}, {2'b00, f});
    rd(REG_TOK, 32'h0010000E);
  endtask
  task automatic s_hold;
    bus(1'b1, REG_TMAX, 32'h4);
    bus(1'b1, REG_CTRL, 32'h3);
    rd(REG_TOK, 32'h00040004);
    put(mk(7'h38, 5'h02, 11'h001, 3'h0, 2'h0));
    put('0);
    fork
      put(mk(7'h38, 5'h04, 11'h002, 3'h0, 2'h0));
      begin
        repeat (20) @(posedge clk);
        rx(mk(7'h00, 5'h01, 11'h000, 3'h2, 2'h0));
      end
    join
    chk_w(32'(wt > 20), 32'h1);
    repeat (3) put('0);
    rd(REG_TOK, 32'h00040000);
    put(mk(CMD_TOKEN_RETURN_PACKET, 5'h01, 11'h000, 3'h0, 2'h0));
    chk_w(32'(wt < 5), 32'h1);
    rd(REG_TOK, 32'h00040000);
    rx(mk(7'h00, 5'h01, 11'h000, 3'h7, 2'h0));
    rd(REG_TOK, 32'h00040004);
    rd(REG_STAT, 32'h1);
    bus(1'b1, REG_STAT, 32'h1);
    rd(REG_STAT, 32'h0);
  endtask
  task automatic s_fwd;
    int n;
    fwd_ready <= 1'b0;
    // Disabled link holds freed tokens back, so they can be seen pending
    bus(1'b1, REG_CTRL, 32'h0);
    s0 = rtc_sum;
    f = mk(7'h38, 5'h01, 11'h3C3, 3'h0, 2'h0);
    rx(f);
    repeat (6) @(posedge clk);
    chk_w({31'h0, fwd_valid}, 32'h1);
    rd(REG_PEND, 32'h00000001);
    bus(1'b1, REG_CTRL, 32'h1);
    fwd_ready <= 1'b1;
    getf();
    chk_f(g, {2'b01, f});
    for (n = 0; n < 40 && rtc_sum == s0; n++) @(posedge clk);
    chk_w(32'(rtc_sum - s0), 32'h1);
    chk_f({2'b00, hdr}, {2'b00, mk(CMD_TOKEN_RETURN_PACKET, 5'h01, 11'h000, 3'h1, 2'h0)});
    rx(mk(7'h38, 5'h01, 11'h3C4, 3'h0, 2'h1));
    getf();
    chk_f(g, {2'b11, mk(7'h38, 5'h01, 11'h3C4, 3'h0, 2'h2)});
    rd(REG_STAT, 32'h2);
    bus(1'b1, REG_STAT, 32'h2);
    f = mk(7'h38, 5'h01, 11'h3C5, 3'h0, 2'h2);
    rx(f);
    getf();
    chk_f(g, {2'b11, f});
    rd(REG_STAT, 32'h4);
    // Marked packet sent out keeps its inverted code after regeneration
    f = mk(7'h38, 5'h01, 11'h3C6, 3'h0, 2'h2);
    put(f);
    repeat (3) @(posedge clk);
    chk_f({2'b00, hdr}, {2'b00, f});
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    s_regs();
    s_tx();
    s_hold();
    s_fwd();
    repeat (5) @(posedge clk);
    wrap_up();
  end
  // Hang guard well above the length of the whole run
  initial begin
    repeat (20000) @(posedge clk);
    tmo();
  end
endmodule // tb_top
